// ### test/cgio_pad_model.sv
// Purpose : Outside circuitry on the pads
// Assumes : Every pad has a pull-up
// Notes   : Outside drives only pads the design leaves released
`timescale 1ns/1ns
module cgio_pad_model (
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] ext_lvl,
   input  wire logic [7:0] ext_oe,
   output logic      [7:0] pad
);
   // Released pads that outside leaves undriven rise to the pull-up, never keep the last value
   assign pad = (pin_oe & pin_out) | (~pin_oe & ((ext_oe & ext_lvl) | ~ext_oe));
endmodule

// ### test/cgio_pin_group_monitor.sv
// Purpose : Port-level assertions for the IO pin group
// Assumes : CONTIGUOUS=1 and the capture stage never selected
// Notes   : Mirrors config writes to know each pin's mode
`timescale 1ns/1ns
module cgio_pin_group_chk #(
   parameter logic [7:0] SPECIAL_IO_MASK = 8'hf0
) (
   input wire logic                    clk,
   input wire logic                    reset,
   input wire cgio_pkg::cgio_bus_req_s bus_req,
   input wire logic [31:0]             bus_rdata,
   input wire logic [7:0]              pin_in,
   input wire logic [7:0]              pin_out,
   input wire logic [7:0]              pin_oe,
   input wire logic [3:0]              vref_pair_en,
   input wire logic [7:0]              vref_drive_sel,
   input wire logic [7:0]              analog_en,
   input wire logic [7:0]              hw_out,
   input wire logic                    hw_oe_bus,
   input wire logic [7:0]              hw_oe_pin,
   input wire logic [7:0]              hw_in,
   input wire logic                    pin_irq
);
   logic [31:0] typ_ff;
   logic [31:0] con_ff;
   logic [23:0] drv_ff;
   logic [7:0]  lvl_ff;
   wire  logic [7:0]  a = bus_req.addr;
   wire  logic [31:0] wd = bus_req.wdata;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         typ_ff <= '0;
         con_ff <= '0;
         drv_ff <= '0;
         lvl_ff <= '0;
      end else if (bus_req.wr) begin
         if (a == cgio_pkg::OFS_PIN_TYPE) typ_ff <= wd;
         if (a == cgio_pkg::OFS_HW_CONNECT) con_ff <= wd;
         if (a == cgio_pkg::OFS_DRIVE_MODE) drv_ff <= wd[23:0];
         if (a == cgio_pkg::OFS_OUT_LEVEL) lvl_ff <= wd[7:0];
         if (a == cgio_pkg::OFS_PIN_ACCESS && wd[8]) lvl_ff[wd[2:0]] <= wd[4];
      end
   end
   wire logic [7:0] bid = typ_ff[31:24];
   wire logic dok = typ_ff[15:8] == 8'hff && bid == 8'h0 && drv_ff == 24'h0;
   wire logic sw = dok && con_ff[15:8] == 8'h0;
   // Hardware path with the enable feature on every pin
   wire logic hwg = dok && con_ff[23:8] == 16'hffff;
   wire logic grp = con_ff[24];
   wire logic clr = bus_req.wr && a == cgio_pkg::OFS_EVT_STATUS;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_drop; pin_irq ##1 !pin_irq; endsequence
   property p_rdata; bus_rdata != 32'h0 |-> $past(bus_req.rd); endproperty
   property p_sw; sw |=> pin_out == $past(lvl_ff) && pin_oe == 8'hff; endproperty
   property p_hw_on;
      hwg && (grp ? hw_oe_bus : hw_oe_pin == 8'hff) |=> pin_oe == 8'hff && pin_out == $past(hw_out);
   endproperty
   property p_grp; hwg && grp |=> pin_oe == {8{$past(hw_oe_bus)}}; endproperty
   property p_pin; hwg && !grp |=> pin_oe == $past(hw_oe_pin); endproperty
   property p_od;
      bid == 8'hff && con_ff[23:16] == 8'h0 && drv_ff == 24'h0 |=>
         pin_out == 8'h0 && pin_oe == ~$past(hw_out);
   endproperty
   property p_hw_in;
      !con_ff[25] |-> (hw_in & ~($past(pin_in, 2) | $past(pin_in, 3) | $past(pin_in, 4))) == 8'h0;
   endproperty
   property p_vref; (vref_drive_sel & (analog_en | ~SPECIAL_IO_MASK)) == 8'h0; endproperty
   property p_pair;
      ({|vref_drive_sel[7:6], |vref_drive_sel[5:4], |vref_drive_sel[3:2],
        |vref_drive_sel[1:0]} & ~vref_pair_en) == 4'h0;
   endproperty
   property p_irq; s_drop |-> $past(clr) || $past(clr, 2); endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside its slot");
   a_sw: assert property (p_sw) else $error("firmware output wrong");
   a_hw_on: assert property (p_hw_on) else $error("enabled driver wrong");
   a_grp: assert property (p_grp) else $error("bus enable not shared");
   a_pin: assert property (p_pin) else $error("per-pin enable wrong");
   a_od: assert property (p_od) else $error("open drain default wrong");
   a_hw_in: assert property (p_hw_in) else $error("hw input without level");
   a_vref: assert property (p_vref) else $error("illegal reference drive");
   a_pair: assert property (p_pair) else $error("pair reference not on");
   a_irq: assert property (p_irq) else $error("event flag dropped alone");
endmodule
bind cgio_pin_group cgio_pin_group_chk #(.SPECIAL_IO_MASK(SPECIAL_IO_MASK)) u_chk (
   .clk, .reset, .bus_req, .bus_rdata, .pin_in, .pin_out, .pin_oe, .vref_pair_en,
   .vref_drive_sel, .analog_en, .hw_out, .hw_oe_bus, .hw_oe_pin, .hw_in, .pin_irq);

// ### test/tb_configurable_io_pin_group.sv
// Purpose : Self-checking bench for the IO pin group
// Assumes : Default parameters; capture stage left off
// Notes   : Outputs are read at the edge, before its updates land
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_configurable_io_pin_group;
   logic                    clk = 1'b0;
   logic                    reset = 1'b1;
   cgio_pkg::cgio_bus_req_s bus_req = '0;
   logic [31:0]             bus_rdata;
   logic [7:0]              pin_in, pin_out, pin_oe, vref_drive_sel, analog_en, hw_in;
   logic [7:0]              hw_out = 8'h0, hw_oe_pin = 8'h0, ext_lvl = 8'h0, ext_oe = 8'h0;
   logic [7:0]              vref_cmp_in = 8'h0;
   logic [3:0]              vref_pair_en;
   logic                    hw_oe_bus = 1'b0, pin_irq;
   int                      checks = 0, n_fail = 0;
   always #5 clk = ~clk;
   cgio_pad_model i_pads (.pin_out, .pin_oe, .ext_lvl, .ext_oe, .pad(pin_in));
   cgio_pin_group i_dut (.clk, .reset, .bus_req, .bus_rdata, .pin_in, .pin_out, .pin_oe,
      .vref_cmp_in, .vref_pair_en, .vref_drive_sel, .analog_en, .hw_out, .hw_oe_bus,
      .hw_oe_pin, .hw_in, .sync_en(1'b0), .sync_rst(1'b0), .pin_irq);
   task automatic tally_and_finish();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      bus_req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      bus_req.rd <= 1'b0;
      @(posedge clk);
      `CHK("bus_rdata", e, bus_rdata)
   endtask
   initial begin
      w(8);
      reset <= 1'b0;
      for (int a = 0; a <= 36; a += 4) rc(8'(a), 32'h0);
      $display("test reset_values done");
      ext_oe <= 8'hff;
      ext_lvl <= 8'ha5;
      wr(cgio_pkg::OFS_PIN_TYPE, 32'hff);
      wr(cgio_pkg::OFS_HW_CONNECT, 32'hff);
      w(6);
      `CHK("hw_in", 8'ha5, hw_in)
      rc(cgio_pkg::OFS_IN_STATE, 32'ha5);
      $display("test input done");
      ext_oe <= 8'h0;
      wr(cgio_pkg::OFS_PIN_TYPE, 32'hff00);
      wr(cgio_pkg::OFS_HW_CONNECT, 32'hff0000);
      wr(cgio_pkg::OFS_OUT_LEVEL, 32'h3c);
      wr(cgio_pkg::OFS_PIN_ACCESS, 32'h110);
      w(3);
      `CHK("pin_out", 8'h3d, pin_out)
      `CHK("pin_oe", 8'hff, pin_oe)
      rc(cgio_pkg::OFS_OUT_LEVEL, 32'h3d);
      $display("test firmware_output done");
      hw_out <= 8'h96;
      hw_oe_bus <= 1'b1;
      wr(cgio_pkg::OFS_HW_CONNECT, 32'h1ffff00);
      w(3);
      `CHK("pin_out", 8'h96, pin_out)
      `CHK("pin_oe", 8'hff, pin_oe)
      hw_oe_bus <= 1'b0;
      hw_oe_pin <= 8'h0f;
      w(3);
      `CHK("pin_oe", 8'h00, pin_oe)
      wr(cgio_pkg::OFS_HW_CONNECT, 32'hffff00);
      w(3);
      `CHK("pin_oe", 8'h0f, pin_oe)
      $display("test hw_enable done");
      hw_out <= 8'h0f;
      wr(cgio_pkg::OFS_PIN_TYPE, 32'hff000000);
      wr(cgio_pkg::OFS_HW_CONNECT, 32'h0);
      w(6);
      `CHK("pin_oe", 8'hf0, pin_oe)
      `CHK("pin_out", 8'h00, pin_out)
      `CHK("hw_in", 8'h0f, hw_in)
      $display("test bidir done");
      ext_oe <= 8'hff;
      ext_lvl <= 8'hff;
      wr(cgio_pkg::OFS_PIN_TYPE, 32'h0);
      wr(cgio_pkg::OFS_VREF_USE, 32'hffff);
      rc(cgio_pkg::OFS_VREF_USE, 32'h0);
      wr(cgio_pkg::OFS_PIN_TYPE, 32'hff);
      wr(cgio_pkg::OFS_VREF_USE, 32'hffff);
      w(6);
      rc(cgio_pkg::OFS_VREF_USE, 32'hf0f0);
      rc(cgio_pkg::OFS_IN_STATE, 32'h0f);
      `CHK("vref_pair_en", 4'hc, vref_pair_en)
      wr(cgio_pkg::OFS_PIN_TYPE, 32'hffffff);
      wr(cgio_pkg::OFS_VREF_USE, 32'hffff);
      w(3);
      rc(cgio_pkg::OFS_VREF_USE, 32'h0);
      `CHK("pin_oe", 8'hff, pin_oe)
      `CHK("analog_en", 8'hff, analog_en)
      $display("test reference done");
      wr(cgio_pkg::OFS_PIN_TYPE, 32'hff);
      ext_lvl <= 8'h0;
      wr(cgio_pkg::OFS_TRIG_KIND, 32'h1);
      w(6);
      wr(cgio_pkg::OFS_EVT_STATUS, 32'hff);
      w(2);
      `CHK("pin_irq", 1'b0, pin_irq)
      ext_lvl <= 8'h01;
      for (int i = 0; i < 8 && pin_irq !== 1'b1; i++) w(1);
      if (pin_irq !== 1'b1) begin
         n_fail++;
         tally_and_finish();
      end
      rc(cgio_pkg::OFS_EVT_STATUS, 32'h1);
      wr(cgio_pkg::OFS_EVT_STATUS, 32'h1);
      ext_lvl <= 8'h0;
      w(6);
      `CHK("pin_irq", 1'b0, pin_irq)
      $display("test event done");
      tally_and_finish();
   end
endmodule

// ### verilog/cgio_pin_group.sv
// Purpose : Configurable IO pin group: readback, driving, output enables,
//           reference-voltage selection and pin event flags
// Assumes : Pin levels and comparator outputs are asynchronous; hardware
//           side inputs are on clk
// Notes   : Register port with read data one cycle after the strobe
//
// Function
// RULE1 - Every digital-input pin's level is readable by software.
// RULE2 - Visible hardware input terminal carries the pin's input level.
// RULE3 - Software writes the level driven by a digital-output pin.
// RULE4 - Hardware output-enable high activates driver per selected drive mode.
// RULE5 - Hardware output-enable low switches the driver off, high impedance.
// RULE6 - Hardware output-enable gates only hardware-driven outputs, never firmware ones.
// RULE7 - Grouped bus presentation: one output-enable controls all pins.
// RULE8 - Without grouped presentation each pin has its own output-enable.
// RULE9 - Reference-voltage use is allowed only on special IO cells.
// RULE10 - Both pins of a special IO pair share one reference input.
// RULE11 - Special IO cell may take input threshold from reference input.
// RULE12 - Reference use needs a digital input or output connection.
// RULE13 - Reference use excludes analog connection of that pin.
// RULE14 - Pin event output only with digital input and configured trigger.
// RULE15 - Wake handler outside must not trigger on low-to-high edge.
// RULE16 - Outside logic may form level requests from the hardware input.
// RULE17 - Level requests from hardware input bypass the pin event logic.
// RULE18 - Synchroniser enable and reset act only when not transparent.
// RULE19 - Digital output may drive while analog connection is present.
// RULE20 - Group access only for contiguous single-port groups, else per pin.
// RULE21 - Without visible hardware terminal, software alone controls the pin.
// RULE22 - Bidirectional pin defaults to open drain driving low.
// RULE23 - Bidirectional pin combines input readback and output driver paths.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module cgio_pin_group #(
   parameter logic [7:0] SPECIAL_IO_MASK = 8'hf0,
   parameter logic       CONTIGUOUS      = 1'b1
) (
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire cgio_pkg::cgio_bus_req_s     bus_req,
   output logic [cgio_pkg::DATA_W-1:0]      bus_rdata,
   input  wire logic [cgio_pkg::PINS-1:0]   pin_in,
   output logic [cgio_pkg::PINS-1:0]        pin_out,
   output logic [cgio_pkg::PINS-1:0]        pin_oe,
   input  wire logic [cgio_pkg::PINS-1:0]   vref_cmp_in,
   output logic [cgio_pkg::PAIRS-1:0]       vref_pair_en,
   output logic [cgio_pkg::PINS-1:0]        vref_drive_sel,
   output logic [cgio_pkg::PINS-1:0]        analog_en,
   input  wire logic [cgio_pkg::PINS-1:0]   hw_out,
   input  wire logic                        hw_oe_bus,
   input  wire logic [cgio_pkg::PINS-1:0]   hw_oe_pin,
   output logic [cgio_pkg::PINS-1:0]        hw_in,
   input  wire logic                        sync_en,
   input  wire logic                        sync_rst,
   output logic                             pin_irq
);

   localparam int unsigned N = cgio_pkg::PINS;

   // ------
   // State
   // ------
   typedef struct packed {
      logic [N-1:0]                out_level;
      logic [N-1:0]                din;
      logic [N-1:0]                dout;
      logic [N-1:0]                analog;
      logic [N-1:0]                bidir;
      logic [N-1:0]                hwin_vis;
      logic [N-1:0]                hwout_vis;
      logic [N-1:0]                oe_feat;
      logic                        grouped;
      logic                        sync_mode;
      logic [23:0]                 drive;
      logic [N-1:0]                thr_vref;
      logic [N-1:0]                drv_vref;
      logic [15:0]                 trig;
      logic [N-1:0]                evt;
      logic [cgio_pkg::IDX_W-1:0]  acc_idx;
      logic [N-1:0]                cap;
      logic [N-1:0]                prev;
      logic [N-1:0]                pin_out;
      logic [N-1:0]                pin_oe;
      logic [N-1:0]                hw_in;
      logic                        irq;
      logic [cgio_pkg::DATA_W-1:0] rdata;
      logic [cgio_pkg::PAIRS-1:0]  vref_pair;
      logic [N-1:0]                vref_drv;
      logic [N-1:0]                analog_en;
   } cgio_state_s;

   cgio_state_s st_ff;
   cgio_state_s nxt_st;

   logic [N-1:0] pin_s;
   logic [N-1:0] cmp_s;

   // ------
   // Pin level and comparator output synchronisers
   // ------
   cgio_sync #(.WIDTH(N)) u_pin_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in (pin_in),
      .sync_out (pin_s)
   );

   cgio_sync #(.WIDTH(N)) u_cmp_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in (vref_cmp_in),
      .sync_out (cmp_s)
   );

   // ------
   // Next-state logic
   // ------
   always_comb begin
      logic [N-1:0]                din_e;
      logic [N-1:0]                dout_e;
      logic [N-1:0]                hwi_path;
      logic [N-1:0]                hwo_path;
      logic [N-1:0]                vref_ok;
      logic [N-1:0]                vref_use;
      logic [N-1:0]                raw;
      logic [N-1:0]                level;
      logic [N-1:0]                hw_oe_sel;
      logic [N-1:0]                ev_set;
      logic [N-1:0]                ev_clr;
      logic [N-1:0]                drv_lvl;
      logic [N-1:0]                drv_on;
      logic [2:0]                  mode;
      logic [1:0]                  kind;
      logic                        wr_hit;
      logic [cgio_pkg::DATA_W-1:0] rd_val;
      din_e     = '0;
      dout_e    = '0;
      hwi_path  = '0;
      hwo_path  = '0;
      vref_ok   = '0;
      vref_use  = '0;
      raw       = '0;
      level     = '0;
      hw_oe_sel = '0;
      ev_set    = '0;
      ev_clr    = '0;
      drv_lvl   = '0;
      drv_on    = '0;
      mode      = cgio_pkg::DRV_DEFAULT;
      kind      = 2'h0;
      wr_hit    = 1'b0;
      rd_val    = cgio_pkg::RST_WORD;
      nxt_st    = st_ff;

      // Bidirectional means input and output, both with hardware terminals
      din_e    = st_ff.din | st_ff.bidir;                                   // RULE23
      dout_e   = st_ff.dout | st_ff.bidir;                                  // RULE23
      hwi_path = st_ff.hwin_vis | st_ff.bidir;                              // RULE23
      hwo_path = st_ff.hwout_vis | st_ff.bidir;                             // RULE23

      // Reference only on special cells with a digital path and no analog
      vref_ok = SPECIAL_IO_MASK & (din_e | dout_e) & ~st_ff.analog;         // RULE9 RULE12 RULE13

      // Threshold from the reference comparator where selected
      raw = (st_ff.thr_vref & vref_ok & din_e & cmp_s)
          | (~(st_ff.thr_vref & vref_ok & din_e) & pin_s);                 // RULE11

      // Optional capture stage; its enable and reset are dead when transparent
      if (st_ff.sync_mode && sync_rst) begin                                // RULE18
         nxt_st.cap = '0;
      end else if (st_ff.sync_mode && sync_en) begin                        // RULE18
         nxt_st.cap = raw;
      end
      level = st_ff.sync_mode ? st_ff.cap : raw;

      nxt_st.hw_in = level & din_e & hwi_path;                              // RULE2
      nxt_st.prev  = level;

      // Pin events straight from the level, independent of hw_in
      for (int i = 0; i < N; i++) begin
         kind = st_ff.trig[i*cgio_pkg::TRIG_W +: cgio_pkg::TRIG_W];
         if (din_e[i]) begin                                               // RULE14 RULE17
            ev_set[i] = ((kind == cgio_pkg::LOW_TO_HIGH_TRIGGER)
                         && level[i] && !st_ff.prev[i])
                      || ((kind == cgio_pkg::TRIG_HIGH_TO_LOW)
                         && !level[i] && st_ff.prev[i])
                      || ((kind == cgio_pkg::TRIG_ANY_EDGE)
                         && (level[i] != st_ff.prev[i]));
         end
      end

      // Output enable source per pin
      hw_oe_sel = st_ff.grouped ? {N{hw_oe_bus}} : hw_oe_pin;             // RULE7 RULE8

      // Driver per pin
      for (int i = 0; i < N; i++) begin
         mode = st_ff.drive[i*cgio_pkg::DRV_W +: cgio_pkg::DRV_W];
         if (mode == cgio_pkg::DRV_DEFAULT) begin
            if (st_ff.bidir[i]) begin
               mode = cgio_pkg::DRV_OD_LOW;                                 // RULE22
            end else if (dout_e[i]) begin
               mode = cgio_pkg::DRV_STRONG;
            end else begin
               mode = cgio_pkg::DRV_HIZ;
            end
         end
         drv_lvl[i] = hwo_path[i] ? hw_out[i] : st_ff.out_level[i];        // RULE3 RULE21
         // Firmware-driven pins ignore the hardware enable
         drv_on[i]  = dout_e[i]
                    && (!(hwo_path[i] && st_ff.oe_feat[i]) || hw_oe_sel[i]); // RULE4 RULE5 RULE6
         case (mode)
            cgio_pkg::DRV_STRONG: begin
               nxt_st.pin_out[i] = drv_lvl[i];
               nxt_st.pin_oe[i]  = drv_on[i];                               // RULE4
            end
            cgio_pkg::DRV_OD_LOW: begin
               nxt_st.pin_out[i] = 1'b0;
               nxt_st.pin_oe[i]  = drv_on[i] && !drv_lvl[i];
            end
            cgio_pkg::DRV_OD_HIGH: begin
               nxt_st.pin_out[i] = 1'b1;
               nxt_st.pin_oe[i]  = drv_on[i] && drv_lvl[i];
            end
            default: begin
               nxt_st.pin_out[i] = 1'b0;
               nxt_st.pin_oe[i]  = 1'b0;                                    // RULE5
            end
         endcase
      end

      // Analog stays on alongside a driven output; shorting is the user's call
      nxt_st.analog_en = st_ff.analog;                                      // RULE19
      nxt_st.vref_drv  = st_ff.drv_vref & vref_ok & dout_e;                 // RULE9
      vref_use = (st_ff.thr_vref | st_ff.drv_vref) & vref_ok;
      for (int p = 0; p < cgio_pkg::PAIRS; p++) begin
         nxt_st.vref_pair[p] = vref_use[2*p] | vref_use[2*p+1]; // RULE10
      end

      // ------
      // Register writes
      // ------
      wr_hit = bus_req.wr;
      if (wr_hit) begin
         case (bus_req.addr)
            cgio_pkg::OFS_OUT_LEVEL: begin
               if (CONTIGUOUS) begin                                        // RULE20
                  nxt_st.out_level = bus_req.wdata[N-1:0];                  // RULE3
               end
            end
            cgio_pkg::OFS_PIN_TYPE: begin
               nxt_st.din    = bus_req.wdata[cgio_pkg::POS_DIN    +: N];
               nxt_st.dout   = bus_req.wdata[cgio_pkg::POS_DOUT   +: N];
               nxt_st.analog = bus_req.wdata[cgio_pkg::POS_ANALOG +: N];
               nxt_st.bidir  = bus_req.wdata[cgio_pkg::POS_BIDIR  +: N];
            end
            cgio_pkg::OFS_HW_CONNECT: begin
               nxt_st.hwin_vis  = bus_req.wdata[cgio_pkg::POS_HWIN_VIS  +: N];
               nxt_st.hwout_vis = bus_req.wdata[cgio_pkg::POS_HWOUT_VIS +: N];
               nxt_st.oe_feat   = bus_req.wdata[cgio_pkg::POS_OE_FEAT   +: N];
               nxt_st.grouped   = bus_req.wdata[cgio_pkg::POS_GROUPED];
               nxt_st.sync_mode = bus_req.wdata[cgio_pkg::POS_SYNC_MODE];
            end
            cgio_pkg::OFS_DRIVE_MODE: begin
               nxt_st.drive = bus_req.wdata[23:0];
            end
            cgio_pkg::OFS_VREF_USE: begin
               nxt_st.thr_vref = bus_req.wdata[cgio_pkg::POS_THR_VREF +: N];
               nxt_st.drv_vref = bus_req.wdata[cgio_pkg::POS_DRV_VREF +: N];
            end
            cgio_pkg::OFS_TRIG_KIND: begin
               nxt_st.trig = bus_req.wdata[15:0];
            end
            cgio_pkg::OFS_EVT_STATUS: begin
               ev_clr = bus_req.wdata[N-1:0];
            end
            cgio_pkg::OFS_PIN_ACCESS: begin
               nxt_st.acc_idx = bus_req.wdata[cgio_pkg::POS_ACC_IDX +: cgio_pkg::IDX_W];
               if (bus_req.wdata[cgio_pkg::POS_ACC_WRITE]) begin            // RULE20
                  nxt_st.out_level[bus_req.wdata[cgio_pkg::POS_ACC_IDX
                                   +: cgio_pkg::IDX_W]] =
                     bus_req.wdata[cgio_pkg::POS_ACC_LEVEL];
               end
            end
            default: begin
            end
         endcase
      end

      // New events win over a clear in the same cycle
      nxt_st.evt = (st_ff.evt & ~ev_clr) | ev_set;
      nxt_st.irq = |nxt_st.evt;                                             // RULE14

      // ------
      // Register reads
      // ------
      case (bus_req.addr)
         cgio_pkg::OFS_OUT_LEVEL:  rd_val[N-1:0] = CONTIGUOUS ? st_ff.out_level : '0;
         cgio_pkg::OFS_IN_STATE:   rd_val[N-1:0] = CONTIGUOUS ? (level & din_e) : '0; // RULE1
         cgio_pkg::OFS_PIN_TYPE:   rd_val = {st_ff.bidir, st_ff.analog, st_ff.dout, st_ff.din};
         cgio_pkg::OFS_HW_CONNECT: rd_val = {6'h00, st_ff.sync_mode, st_ff.grouped,
                                             st_ff.oe_feat, st_ff.hwout_vis, st_ff.hwin_vis};
         cgio_pkg::OFS_DRIVE_MODE: rd_val[23:0] = st_ff.drive;
         cgio_pkg::OFS_VREF_USE:   rd_val[15:0] = {st_ff.drv_vref & vref_ok,
                                                   st_ff.thr_vref & vref_ok};
         cgio_pkg::OFS_TRIG_KIND:  rd_val[15:0] = st_ff.trig;
         cgio_pkg::OFS_EVT_STATUS: rd_val[N-1:0] = st_ff.evt;
         cgio_pkg::OFS_PIN_ACCESS: begin
            rd_val[cgio_pkg::POS_ACC_IDX +: cgio_pkg::IDX_W] = st_ff.acc_idx;
            rd_val[cgio_pkg::POS_ACC_LEVEL] = level[st_ff.acc_idx] & din_e[st_ff.acc_idx]; // RULE1
         end
         default:                  rd_val = cgio_pkg::RST_WORD;
      endcase
      nxt_st.rdata = bus_req.rd ? rd_val : cgio_pkg::RST_WORD;
   end

   // ------
   // State register
   // ------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_ff       <= '0;
         st_ff.drive <= cgio_pkg::RST_DRIVE;
         st_ff.trig  <= cgio_pkg::RST_TRIG;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------
   // Outputs, all straight from flip-flops
   // ------
   assign bus_rdata      = st_ff.rdata;
   assign pin_out        = st_ff.pin_out;
   assign pin_oe         = st_ff.pin_oe;
   assign hw_in          = st_ff.hw_in;
   assign pin_irq        = st_ff.irq;
   assign vref_pair_en   = st_ff.vref_pair;
   assign vref_drive_sel = st_ff.vref_drv;
   assign analog_en      = st_ff.analog_en;

endmodule

// ### verilog/cgio_pkg.sv
// Purpose : Shared constants and types for the configurable IO pin group
// Assumes : 32-bit register word, byte addresses in steps of four
// Notes   : All offsets, codes and reset values live here
package cgio_pkg;

   // ------
   // Geometry
   // ------
   localparam int unsigned PINS       = 8;
   localparam int unsigned PAIRS      = PINS / 2;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned DRV_W      = 3;
   localparam int unsigned TRIG_W     = 2;
   localparam int unsigned IDX_W      = 3;

   // ------
   // Register byte offsets
   // ------
   localparam logic [7:0] OFS_OUT_LEVEL  = 8'h00;
   localparam logic [7:0] OFS_IN_STATE   = 8'h04;
   localparam logic [7:0] OFS_PIN_TYPE   = 8'h08;
   localparam logic [7:0] OFS_HW_CONNECT = 8'h0c;
   localparam logic [7:0] OFS_DRIVE_MODE = 8'h10;
   localparam logic [7:0] OFS_VREF_USE   = 8'h14;
   localparam logic [7:0] OFS_TRIG_KIND  = 8'h18;
   localparam logic [7:0] OFS_EVT_STATUS = 8'h1c;
   localparam logic [7:0] OFS_PIN_ACCESS = 8'h20;

   // ------
   // Field positions
   // ------
   localparam int unsigned POS_DIN       = 0;
   localparam int unsigned POS_DOUT      = 8;
   localparam int unsigned POS_ANALOG    = 16;
   localparam int unsigned POS_BIDIR     = 24;
   localparam int unsigned POS_HWIN_VIS  = 0;
   localparam int unsigned POS_HWOUT_VIS = 8;
   localparam int unsigned POS_OE_FEAT   = 16;
   localparam int unsigned POS_GROUPED   = 24;
   localparam int unsigned POS_SYNC_MODE = 25;
   localparam int unsigned POS_THR_VREF  = 0;
   localparam int unsigned POS_DRV_VREF  = 8;
   localparam int unsigned POS_ACC_IDX   = 0;
   localparam int unsigned POS_ACC_LEVEL = 4;
   localparam int unsigned POS_ACC_WRITE = 8;

   // ------
   // Drive mode codes, three bits per pin
   // ------
   localparam logic [2:0] DRV_DEFAULT = 3'h0;
   localparam logic [2:0] DRV_HIZ     = 3'h1;
   localparam logic [2:0] DRV_STRONG  = 3'h2;
   localparam logic [2:0] DRV_OD_LOW  = 3'h3;
   localparam logic [2:0] DRV_OD_HIGH = 3'h4;

   // ------
   // Event trigger kinds, two bits per pin
   // ------
   typedef enum logic [1:0] {
      TRIG_NONE          = 2'h0,
      LOW_TO_HIGH_TRIGGER = 2'h1,
      TRIG_HIGH_TO_LOW   = 2'h2,
      TRIG_ANY_EDGE      = 2'h3
   } cgio_trig_e;

   // ------
   // Reset values
   // ------
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [23:0] RST_DRIVE = 24'h000000;
   localparam logic [15:0] RST_TRIG  = 16'h0000;
   localparam logic [31:0] RST_WORD  = 32'h00000000;

   // ------
   // Carriers
   // ------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } cgio_bus_req_s;

   typedef struct packed {
      logic [PINS-1:0] level;
      logic [PINS-1:0] oe;
   } cgio_drive_s;

endpackage

// ### verilog/cgio_sync.sv
// Purpose : Two-stage synchroniser for pin levels entering the clock domain
// Assumes : Inputs are asynchronous to clk
// Notes   : First stage feeds only the second stage
`timescale 1ns/1ns
module cgio_sync #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } cgio_sync_s;

   cgio_sync_s st_ff;
   cgio_sync_s nxt_st;

   always_comb begin
      nxt_st        = st_ff;
      nxt_st.stage1 = async_in;
      nxt_st.stage2 = st_ff.stage1;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.stage2;

endmodule
